//--- dv/conv_engine_model.sv
// behavioural converter: one result per channel after each temperature start
`timescale 1ns/1ps
module conv_engine_model (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic slow,
  input wire logic [3:0][limit_sched_pkg::TEMP_W-1:0] temp_set,
  output logic meas_valid,
  output logic [1:0] meas_chan,
  output logic [limit_sched_pkg::TEMP_W-1:0] meas_temp
);
  int wait_cnt;
  int ch;
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meas_valid <= 1'b0;
      meas_chan <= 2'h0;
      meas_temp <= '0;
      wait_cnt <= 0;
      ch <= 4;
    end else begin
      meas_valid <= 1'b0;
      // released result lines must not keep showing the last value
      if (meas_valid) begin
        meas_chan <= ~meas_chan;
        meas_temp <= ~meas_temp;
      end
      if (start) begin
        wait_cnt <= slow ? 6 : 0;
        ch <= 0;
      end else if (wait_cnt > 0) begin
        wait_cnt <= wait_cnt - 1;
      end else if (ch < 4) begin
        meas_valid <= 1'b1;
        meas_chan <= ch[1:0];
        meas_temp <= temp_set[ch];
        ch <= ch + 1;
      end
    end
  end
endmodule

//--- dv/temp_limit_compare_sched_tb.sv
// self-checking bench for the limit comparator and conversion scheduler
`timescale 1ns/1ps
module temp_limit_compare_sched_tb;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic temperature_halt = 1'b1;
  // voltage path halted too, so periodic voltage ticks cannot land on a start check
  logic current_path_halt = 1'b1;
  logic alert_mask_all = 1'b0;
  logic slow = 1'b0;
  logic meas_valid, temp_conv_start, volt_conv_start;
  logic alarm_output, critical_alarm_output, crit_summary;
  logic [1:0] meas_chan;
  logic [limit_sched_pkg::TEMP_W-1:0] meas_temp;
  logic [3:0] high_status, low_status, crit_status;
  // ch3 20.0, ch2 100.0, ch1 -128.0, ch0 85.0 in eighths of a degree
  logic [3:0][10:0] temps = {11'h0a0, 11'h320, 11'h400, 11'h2a8};
  int n_mismatch = 0;
  int checks = 0;
  int n, v;
  localparam logic [15:0] RST_TAB [27] = '{16'h0406, 16'h0a06, 16'h0555, 16'h0b55,
    16'h0680, 16'h0c80, 16'h0755, 16'h0d55, 16'h0880, 16'h0e80, 16'h1300, 16'h1400,
    16'h1555, 16'h1680, 16'h1700, 16'h1800, 16'h1964, 16'h1a64, 16'h2064, 16'h210a,
    16'h2c55, 16'h2d80, 16'h2e00, 16'h2f00, 16'h3064, 16'h0f00, 16'h0100};

  always #4 sys_clk = ~sys_clk;

  limit_compare_sched #(.FASTEST_PERIOD_CYCLES(8)) i_limit_compare_sched (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .temperature_halt(temperature_halt), .current_path_halt(current_path_halt),
    .alert_mask_all(alert_mask_all), .meas_valid(meas_valid), .meas_chan(meas_chan),
    .meas_temp(meas_temp), .temp_conv_start(temp_conv_start),
    .volt_conv_start(volt_conv_start), .alarm_output(alarm_output),
    .critical_alarm_output(critical_alarm_output), .high_status(high_status),
    .low_status(low_status), .crit_status(crit_status), .crit_summary(crit_summary));

  conv_engine_model i_conv_engine_model (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .start(temp_conv_start), .slow(slow),
    .temp_set(temps), .meas_valid(meas_valid), .meas_chan(meas_chan),
    .meas_temp(meas_temp));

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // all bus tasks are entered right after a rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] val);
    reg_addr <= a;
    reg_wdata <= val;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    @(negedge sys_clk);
    chk($sformatf("register %h", a), {3'h0, exp}, {3'h0, reg_rdata});
    @(posedge sys_clk);
  endtask

  task automatic shot(input logic exp_t, input logic exp_v);
    wr(8'h0f, 8'hff);
    @(negedge sys_clk);
    chk("temperature start", {10'h0, exp_t}, {10'h0, temp_conv_start});
    chk("voltage start", {10'h0, exp_v}, {10'h0, volt_conv_start});
    @(posedge sys_clk);
  endtask

  // last channel result, then the two-cycle path to the alarm outputs
  task automatic settle;
    n = 0;
    while (!(meas_valid === 1'b1 && meas_chan === 2'h3) && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 40) begin
      n_mismatch++;
      $display("wrong value result wait expected done seen timeout");
      end_sim;
    end
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic wait_start(output int c);
    c = 0;
    do begin
      @(negedge sys_clk);
      c++;
    end while (temp_conv_start !== 1'b1 && c < 5000);
    if (c >= 5000) begin
      n_mismatch++;
      $display("wrong value start wait expected pulse seen none");
      end_sim;
    end
  endtask

  initial begin
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    foreach (RST_TAB[i]) rd_chk(RST_TAB[i][15:8], RST_TAB[i][7:0]);
    $display("test reset values done");
    wr(8'h0a, 8'hff);
    rd_chk(8'h04, 8'h07);
    wr(8'h0c, 8'hc0);
    rd_chk(8'h06, 8'hc0);
    wr(8'h21, 8'hff);
    rd_chk(8'h21, 8'h7f);
    wr(8'h21, 8'h0a);
    @(posedge sys_clk);
    wr(8'h13, 8'hff);
    rd_chk(8'h13, 8'he0);
    wr(8'h0f, 8'h5a);
    rd_chk(8'h0f, 8'h00);
    $display("test access and aliases done");
    slow <= 1'b1;
    shot(1'b1, 1'b1);
    settle;
    chk("high status", 11'h5, {7'h0, high_status});
    chk("low status", 11'h2, {7'h0, low_status});
    chk("crit status", 11'h4, {7'h0, crit_status});
    chk("alarm", 11'h1, {10'h0, alarm_output});
    chk("critical alarm", 11'h1, {10'h0, critical_alarm_output});
    chk("crit summary", 11'h1, {10'h0, crit_summary});
    alert_mask_all <= 1'b1;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("masked alarm", 11'h0, {10'h0, alarm_output});
    chk("unmasked critical", 11'h1, {10'h0, critical_alarm_output});
    @(posedge sys_clk);
    alert_mask_all <= 1'b0;
    $display("test compare and mask done");
    wr(8'h2c, 8'h10);
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("limit before conversion", 11'h0, {10'h0, high_status[3]});
    @(posedge sys_clk);
    shot(1'b1, 1'b1);
    settle;
    chk("limit after conversion", 11'hd, {7'h0, high_status});
    $display("test halted limit write done");
    wr(8'h07, 8'h50);
    @(posedge sys_clk);
    wr(8'h13, 8'h20);
    // pass 0 sits on the release threshold, pass 1 one degree below it
    for (int i = 0; i < 2; i++) begin
      temps[1] <= (i == 1) ? 11'h281 : 11'h280;
      temps[2] <= (i == 1) ? 11'h2c8 : 11'h2d0;
      shot(1'b1, 1'b1);
      settle;
      chk("critical alarm", {10'h0, i == 0}, {10'h0, critical_alarm_output});
      chk("crit status", (i == 1) ? 11'h0 : 11'h4, {7'h0, crit_status});
      chk("crit summary", {10'h0, i == 0}, {10'h0, crit_summary});
      chk("fraction high", {10'h0, i == 1}, {10'h0, high_status[1]});
    end
    $display("test hysteresis and fraction done");
    wr(8'h04, 8'h00);
    current_path_halt <= 1'b1;
    temperature_halt <= 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk("start on halt clear", 11'h1, {10'h0, temp_conv_start});
    @(posedge sys_clk);
    shot(1'b0, 1'b1);
    current_path_halt <= 1'b0;
    @(posedge sys_clk);
    shot(1'b0, 1'b0);
    $display("test start sources done");
    for (int code = 7; code >= 0; code--) begin
      wr(8'h04, 8'(code));
      wait_start(n);
      wait_start(n);
      chk("interval", 11'(8 << (7 - code)), 11'(n));
      @(posedge sys_clk);
    end
    $display("test conversion rates done");
    temperature_halt <= 1'b1;
    wr(8'h04, 8'h07);
    n = 0;
    v = 0;
    repeat (100) begin
      @(negedge sys_clk);
      n += int'(temp_conv_start);
      v += int'(volt_conv_start);
    end
    chk("periodic temperature starts", 11'h0, 11'(n));
    chk("periodic voltage starts", 11'h1, {10'h0, v > 0});
    $display("test halted periodic done");
    end_sim;
  end
endmodule

//--- logic/interval_if.sv
// rate code and periodic start tick between scheduler and interval timer
`timescale 1ns/1ps
interface interval_if;
  logic [limit_sched_pkg::RATE_W-1:0] rate_code;
  logic tick;
  modport timer (input rate_code, output tick);
  modport user (output rate_code, input tick);
endinterface

//--- logic/interval_timer.sv
// free-running conversion interval counter
`timescale 1ns/1ps
module interval_timer #(
  parameter int unsigned BASE_CYCLES = limit_sched_pkg::FASTEST_PERIOD_CYCLES,
  parameter int unsigned CNT_W = 31
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  interval_if.timer tmr
);
  logic [CNT_W-1:0] count;
  logic [limit_sched_pkg::RATE_W-1:0] last_rate;
  logic tick_q;

  if (BASE_CYCLES < 2 || (64'(BASE_CYCLES) << limit_sched_pkg::RATE_MAX_SHIFT) >= (64'd1 << CNT_W))
  begin : g_bad_base
    $error("interval_timer: BASE_CYCLES out of range for counter width");
  end

  // slowest code is the fastest period shifted up by seven
  wire [limit_sched_pkg::RATE_W-1:0] shift =
    limit_sched_pkg::RATE_FASTEST_CODE - tmr.rate_code;
  wire [63:0] period_full = 64'(BASE_CYCLES) << shift;
  wire [CNT_W-1:0] period_last = CNT_W'(period_full - 64'd1);
  wire rate_changed = tmr.rate_code != last_rate;
  wire at_end = count == period_last;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= '0;
      last_rate <= limit_sched_pkg::RATE_RESET;
      tick_q <= 1'b0;
    end else begin
      last_rate <= tmr.rate_code;
      tick_q <= at_end && !rate_changed;
      // restart on a new rate so it counts a whole interval of the new length
      if (rate_changed || at_end) begin
        count <= '0;
      end else begin
        count <= count + 1'b1;
      end
    end
  end

  assign tmr.tick = tick_q;

  property p_reload;
    @(posedge sys_clk) disable iff (sys_rst)
    rate_changed |=> count == '0 && !tick_q;
  endproperty
  a_reload: assert property (p_reload) else $error("counter not reloaded on rate change");

  property p_tick_apart;
    @(posedge sys_clk) disable iff (sys_rst)
    tick_q |=> !tick_q;
  endproperty
  a_tick_apart: assert property (p_tick_apart) else $error("interval ticks back to back");
endmodule

//--- logic/limit_compare_sched.sv
// conversion scheduling, limit registers and high/low/critical comparison
// Notes on behaviour
// - the selected rate paces refresh and limit checks of voltage and temperature
// - rate bits 2:0: 16s,8s,4s,2s,1s, then 2,4,8 per second; reset 4/s
// - rate register behaves identically at both of its addresses
// - aliased limit registers reach one storage through either address
// - temperature at or above high limit sets high status and alarm
// - temperature at or below low limit sets low status and alarm
// - limits written while halted act only from the next finished conversion
// - while halted, one-shot write or clearing temperature halt starts a cycle
// - one-shot write updates exactly the halted channel groups
// - one-shot write with nothing halted starts nothing
// - current path halted: one-shot measures sense and source voltage once
// - temperature halted: one-shot measures every temperature channel once
// - temperature at or above its critical limit asserts critical alarm; reset 100
// - no mask of any kind reaches the critical alarm
// - critical releases below limit minus seven-bit shared margin; margin resets 10
// - temperatures two's complement, integer high byte, eighths in bits 7:5
// - temperature halt stops periodic temperature conversions; only one-shot refreshes
// - critical summary follows the condition and clears without a read
`timescale 1ns/1ps
module limit_compare_sched #(
  parameter int unsigned FASTEST_PERIOD_CYCLES = limit_sched_pkg::FASTEST_PERIOD_CYCLES
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic temperature_halt,
  input wire logic current_path_halt,
  input wire logic alert_mask_all,
  input wire logic meas_valid,
  input wire logic [1:0] meas_chan,
  input wire logic [limit_sched_pkg::TEMP_W-1:0] meas_temp,
  output logic temp_conv_start,
  output logic volt_conv_start,
  output logic alarm_output,
  output logic critical_alarm_output,
  output logic [limit_sched_pkg::NUM_CHAN-1:0] high_status,
  output logic [limit_sched_pkg::NUM_CHAN-1:0] low_status,
  output logic [limit_sched_pkg::NUM_CHAN-1:0] crit_status,
  output logic crit_summary
);
  localparam int unsigned NC = limit_sched_pkg::NUM_CHAN;
  localparam int unsigned FM = limit_sched_pkg::FRAC_MSB;
  localparam int unsigned FL = limit_sched_pkg::FRAC_LSB;

  logic [limit_sched_pkg::RATE_W-1:0] rate_code;
  logic [limit_sched_pkg::MARGIN_W-1:0] margin;
  logic [7:0] high_int [NC];
  logic [7:0] low_int [NC];
  logic [7:0] high_frac [NC];
  logic [7:0] low_frac [NC];
  logic [7:0] crit_limit [NC];
  logic prev_temperature_halt;
  logic crit_any;
  logic [7:0] rd_value;

  interval_if ivl ();

  assign ivl.rate_code = rate_code;

  interval_timer #(
    .BASE_CYCLES(FASTEST_PERIOD_CYCLES),
    .CNT_W(31)
  ) u_interval (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .tmr(ivl.timer)
  );

  // ---- register decode ----
  wire wr_rate = reg_write &&
    (reg_addr == limit_sched_pkg::RATE_ADDR || reg_addr == limit_sched_pkg::RATE_ALIAS);
  wire rd_rate = reg_addr == limit_sched_pkg::RATE_ADDR ||
    reg_addr == limit_sched_pkg::RATE_ALIAS;
  wire hit_margin = reg_addr == limit_sched_pkg::MARGIN_ADDR;
  wire wr_margin = reg_write && hit_margin;
  wire oneshot_wr = reg_write && reg_addr == limit_sched_pkg::ONESHOT_ADDR;

  wire [NC-1:0] hit_hi;
  wire [NC-1:0] hit_lo;
  wire [NC-1:0] hit_hf;
  wire [NC-1:0] hit_lf;
  wire [NC-1:0] hit_cr;
  wire [7:0] rd_part [NC];

  for (genvar ch = 0; ch < NC; ch++) begin : g_dec
    assign hit_hi[ch] = reg_addr == limit_sched_pkg::HIGH_INT_ADDR[ch] ||
      reg_addr == limit_sched_pkg::HIGH_INT_ALIAS[ch];
    assign hit_lo[ch] = reg_addr == limit_sched_pkg::LOW_INT_ADDR[ch] ||
      reg_addr == limit_sched_pkg::LOW_INT_ALIAS[ch];
    assign hit_cr[ch] = reg_addr == limit_sched_pkg::CRIT_ADDR[ch];
    // the internal channel carries no fraction limit registers
    if (ch == 0) begin : g_nofrac
      assign hit_hf[ch] = 1'b0;
      assign hit_lf[ch] = 1'b0;
    end else begin : g_frac
      assign hit_hf[ch] = reg_addr == limit_sched_pkg::HIGH_FRAC_ADDR[ch];
      assign hit_lf[ch] = reg_addr == limit_sched_pkg::LOW_FRAC_ADDR[ch];
    end
    assign rd_part[ch] = (hit_hi[ch] ? high_int[ch] : 8'h00) |
      (hit_lo[ch] ? low_int[ch] : 8'h00) |
      (hit_hf[ch] ? high_frac[ch] : 8'h00) |
      (hit_lf[ch] ? low_frac[ch] : 8'h00) |
      (hit_cr[ch] ? crit_limit[ch] : 8'h00);
  end

  // one-shot and unmapped offsets fall through to zero
  always_comb begin
    rd_value = rd_rate ? {5'h00, rate_code} : 8'h00;
    if (hit_margin) begin
      rd_value = rd_value | {1'b0, margin};
    end
    for (int c = 0; c < NC; c++) begin
      rd_value = rd_value | rd_part[c];
    end
  end

  // ---- register storage ----
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rate_code <= limit_sched_pkg::RATE_RESET;
      margin <= limit_sched_pkg::MARGIN_RESET;
      reg_rdata <= 8'h00;
    end else begin
      if (wr_rate) begin
        rate_code <= reg_wdata[limit_sched_pkg::RATE_W-1:0];
      end
      if (wr_margin) begin
        margin <= reg_wdata[limit_sched_pkg::MARGIN_W-1:0];
      end
      if (reg_read) begin
        reg_rdata <= rd_value;
      end
    end
  end

  // fraction bits below bit 5 are not stored, so they read back as zero
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int c = 0; c < NC; c++) begin
        high_int[c] <= limit_sched_pkg::HIGH_RESET;
        low_int[c] <= limit_sched_pkg::LOW_RESET;
        high_frac[c] <= limit_sched_pkg::FRAC_RESET;
        low_frac[c] <= limit_sched_pkg::FRAC_RESET;
        crit_limit[c] <= limit_sched_pkg::CRIT_RESET;
      end
    end else if (reg_write) begin
      for (int c = 0; c < NC; c++) begin
        if (hit_hi[c]) begin
          high_int[c] <= reg_wdata;
        end
        if (hit_lo[c]) begin
          low_int[c] <= reg_wdata;
        end
        if (hit_hf[c]) begin
          high_frac[c] <= {reg_wdata[FM:FL], 5'h00};
        end
        if (hit_lf[c]) begin
          low_frac[c] <= {reg_wdata[FM:FL], 5'h00};
        end
        if (hit_cr[c]) begin
          crit_limit[c] <= reg_wdata;
        end
      end
    end
  end

  // ---- conversion scheduling ----
  wire halt_release = prev_temperature_halt && !temperature_halt;
  wire next_temp_start = (ivl.tick && !temperature_halt) ||
    (oneshot_wr && temperature_halt) || halt_release;
  // the periodic rate always paces the source voltage unless that path is halted
  wire next_volt_start = (ivl.tick && !current_path_halt) ||
    (oneshot_wr && current_path_halt);

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_temperature_halt <= 1'b0;
      temp_conv_start <= 1'b0;
      volt_conv_start <= 1'b0;
    end else begin
      prev_temperature_halt <= temperature_halt;
      temp_conv_start <= next_temp_start;
      volt_conv_start <= next_volt_start;
    end
  end

  // ---- limit comparison ----
  // limits are sampled only when a result arrives, so writes made while
  // halted stay invisible until the next conversion finishes
  wire signed [11:0] temp_s = {meas_temp[limit_sched_pkg::TEMP_W-1], meas_temp};
  wire signed [11:0] high_s = {high_int[meas_chan][7], high_int[meas_chan],
    high_frac[meas_chan][FM:FL]};
  wire signed [11:0] low_s = {low_int[meas_chan][7], low_int[meas_chan],
    low_frac[meas_chan][FM:FL]};
  wire signed [11:0] crit_s = {crit_limit[meas_chan][7], crit_limit[meas_chan], 3'h0};
  // nine bits hold limit minus margin down to -255 without wrapping
  wire signed [8:0] release_int = {crit_limit[meas_chan][7], crit_limit[meas_chan]} -
    {2'b00, margin};
  wire signed [11:0] release_s = {release_int, 3'h0};
  wire high_hit = temp_s >= high_s;
  wire low_hit = temp_s <= low_s;
  wire crit_hit = temp_s >= crit_s;
  wire crit_release = temp_s < release_s;
  wire next_crit = crit_hit || (crit_status[meas_chan] && !crit_release);

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      high_status <= '0;
      low_status <= '0;
      crit_status <= '0;
    end else if (meas_valid) begin
      high_status[meas_chan] <= high_hit;
      low_status[meas_chan] <= low_hit;
      crit_status[meas_chan] <= next_crit;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      alarm_output <= 1'b0;
      crit_any <= 1'b0;
    end else begin
      alarm_output <= (|high_status || |low_status) && !alert_mask_all;
      crit_any <= |crit_status;
    end
  end

  assign critical_alarm_output = crit_any;
  assign crit_summary = crit_any;

  // ---- checks ----
  sequence s_crit_result;
    meas_valid && crit_hit;
  endsequence

  sequence s_crit_raise;
    ##1 crit_status != '0 ##1 critical_alarm_output;
  endsequence

  property p_crit_assert;
    @(posedge sys_clk) disable iff (sys_rst)
    s_crit_result |-> s_crit_raise;
  endproperty
  a_crit_assert: assert property (p_crit_assert) else $error("critical alarm missed");

  property p_crit_hold;
    @(posedge sys_clk) disable iff (sys_rst)
    meas_valid && crit_status[meas_chan] && !crit_release |=>
      crit_status[$past(meas_chan)];
  endproperty
  a_crit_hold: assert property (p_crit_hold) else $error("critical released inside margin");

  property p_summary_clear;
    @(posedge sys_clk) disable iff (sys_rst)
    crit_status == '0 |=> !crit_summary && !critical_alarm_output;
  endproperty
  a_summary_clear: assert property (p_summary_clear) else $error("summary stuck");

  property p_high;
    @(posedge sys_clk) disable iff (sys_rst)
    meas_valid && temp_s >= high_s |=> high_status[$past(meas_chan)];
  endproperty
  a_high: assert property (p_high) else $error("high status not set");

  property p_low;
    @(posedge sys_clk) disable iff (sys_rst)
    meas_valid && temp_s <= low_s |=> low_status[$past(meas_chan)];
  endproperty
  a_low: assert property (p_low) else $error("low status not set");

  property p_alarm;
    @(posedge sys_clk) disable iff (sys_rst)
    meas_valid && high_hit && !alert_mask_all ##1 !alert_mask_all |=> alarm_output;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm not raised");

  property p_oneshot_idle;
    @(posedge sys_clk) disable iff (sys_rst)
    oneshot_wr && !temperature_halt && !current_path_halt && !ivl.tick &&
      !prev_temperature_halt |=> !temp_conv_start && !volt_conv_start;
  endproperty
  a_oneshot_idle: assert property (p_oneshot_idle) else $error("one-shot not ignored");

  property p_oneshot_temp;
    @(posedge sys_clk) disable iff (sys_rst)
    oneshot_wr && temperature_halt |=> temp_conv_start;
  endproperty
  a_oneshot_temp: assert property (p_oneshot_temp) else $error("no temperature one-shot");

  property p_oneshot_volt;
    @(posedge sys_clk) disable iff (sys_rst)
    oneshot_wr && current_path_halt |=> volt_conv_start;
  endproperty
  a_oneshot_volt: assert property (p_oneshot_volt) else $error("no voltage one-shot");

  property p_release_start;
    @(posedge sys_clk) disable iff (sys_rst)
    $fell(temperature_halt) |=> temp_conv_start;
  endproperty
  a_release_start: assert property (p_release_start) else $error("no start on halt clear");

  property p_halted_quiet;
    @(posedge sys_clk) disable iff (sys_rst)
    temperature_halt && prev_temperature_halt && !oneshot_wr |=> !temp_conv_start;
  endproperty
  a_halted_quiet: assert property (p_halted_quiet) else $error("periodic start while halted");

  property p_oneshot_reads_zero;
    @(posedge sys_clk) disable iff (sys_rst)
    reg_read && reg_addr == limit_sched_pkg::ONESHOT_ADDR |=> reg_rdata == 8'h00;
  endproperty
  a_oneshot_reads_zero: assert property (p_oneshot_reads_zero) else $error("one-shot read");

  property p_rate_alias;
    @(posedge sys_clk) disable iff (sys_rst)
    reg_write && reg_addr == limit_sched_pkg::RATE_ALIAS |=>
      rate_code == $past(reg_wdata[limit_sched_pkg::RATE_W-1:0]);
  endproperty
  a_rate_alias: assert property (p_rate_alias) else $error("rate alias write lost");
endmodule

//--- logic/limit_sched_pkg.sv
// constants for the conversion scheduler and limit comparator
package limit_sched_pkg;
  localparam int unsigned NUM_CHAN = 4;
  localparam int unsigned TEMP_W = 11;
  localparam int unsigned RATE_W = 3;
  localparam int unsigned MARGIN_W = 7;
  localparam int unsigned FRAC_MSB = 7;
  localparam int unsigned FRAC_LSB = 5;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned FASTEST_PERIOD_MS = 125;
  localparam int unsigned FASTEST_PERIOD_CYCLES = FASTEST_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [RATE_W-1:0] RATE_FASTEST_CODE = 3'h7;
  localparam int unsigned RATE_MAX_SHIFT = 7;
  // register offsets; channel 0 internal, 1..3 remote
  localparam logic [7:0] RATE_ADDR = 8'h04;
  localparam logic [7:0] RATE_ALIAS = 8'h0a;
  localparam logic [7:0] ONESHOT_ADDR = 8'h0f;
  localparam logic [7:0] MARGIN_ADDR = 8'h21;
  localparam logic [7:0] HIGH_INT_ADDR [NUM_CHAN] = '{8'h05, 8'h07, 8'h15, 8'h2c};
  localparam logic [7:0] HIGH_INT_ALIAS [NUM_CHAN] = '{8'h0b, 8'h0d, 8'h15, 8'h2c};
  localparam logic [7:0] LOW_INT_ADDR [NUM_CHAN] = '{8'h06, 8'h08, 8'h16, 8'h2d};
  localparam logic [7:0] LOW_INT_ALIAS [NUM_CHAN] = '{8'h0c, 8'h0e, 8'h16, 8'h2d};
  localparam logic [7:0] HIGH_FRAC_ADDR [NUM_CHAN] = '{8'h00, 8'h13, 8'h17, 8'h2e};
  localparam logic [7:0] LOW_FRAC_ADDR [NUM_CHAN] = '{8'h00, 8'h14, 8'h18, 8'h2f};
  localparam logic [7:0] CRIT_ADDR [NUM_CHAN] = '{8'h20, 8'h19, 8'h1a, 8'h30};
  // reset values
  localparam logic [RATE_W-1:0] RATE_RESET = 3'h6;
  localparam logic [7:0] HIGH_RESET = 8'h55;
  localparam logic [7:0] LOW_RESET = 8'h80;
  localparam logic [7:0] FRAC_RESET = 8'h00;
  localparam logic [7:0] CRIT_RESET = 8'h64;
  localparam logic [MARGIN_W-1:0] MARGIN_RESET = 7'h0a;
endpackage
